// File: hw/async_request_node_filter_high.sv
// Purpose: Upper-node acceptance filter for incoming asynchronous requests
// Assumes: Link logic and register master share mclk
// Notes:   Verdict follows a request by one cycle; rejects are counted
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
module async_request_node_filter_high
  import async_filter_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdData,
  input  wire pkt_req_s          pktReq,
  input  wire logic [BUS_W-1:0]  localBusId,
  output verdict_s               verdict,
  output logic      [DATA_W-1:0] filterMask
);

  // ===================================================================
  // Address decode
  function automatic logic isFilterAddr(input logic [ADDR_W-1:0] a);
    isFilterAddr = (a == OFS_FILTER_SET) || (a == OFS_FILTER_CLEAR);
  endfunction : isFilterAddr

  logic [DATA_W-1:0] mask_reg;
  logic [DATA_W-1:0] mask_next;
  logic [DATA_W-1:0] rdData_reg;
  logic [DATA_W-1:0] rdData_next;
  verdict_s          verdict_reg;
  verdict_s          verdict_next;
  logic [CNT_W-1:0]  rejectCount_reg;
  logic [CNT_W-1:0]  rejectCount_next;
  logic              countClear;
  logic              rejectEvent;

  // ===================================================================
  // Decision
  filter_decide u_decide (
    .mask       (mask_reg),
    .req        (pktReq),
    .localBusId (localBusId),
    .verdict    (verdict_next)
  );

  // ===================================================================
  // Mask register
  // Set and clear at distinct addresses, so no read-modify-write race
  always_comb begin
    mask_next = mask_reg;
    if (regWr && regAddr == OFS_FILTER_SET) begin
      mask_next = mask_reg | regWrData;
    end else if (regWr && regAddr == OFS_FILTER_CLEAR) begin
      mask_next = mask_reg & ~regWrData;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mask_reg <= FILTER_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // ===================================================================
  // Read port
  always_comb begin
    rdData_next = READ_IDLE;
    if (regRd && isFilterAddr(regAddr)) begin
      rdData_next = mask_reg;
    end else if (regRd && regAddr == OFS_REJECT_COUNT) begin
      rdData_next = {{(DATA_W-CNT_W){1'b0}}, rejectCount_reg};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdData_reg <= READ_IDLE;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  // ===================================================================
  // Reject counter
  // Saturates rather than wraps so software never sees a false low count
  always_comb begin
    countClear  = regWr && regAddr == OFS_REJECT_COUNT;
    rejectEvent = verdict_next.governed && !verdict_next.accept;
    rejectCount_next = rejectCount_reg;
    if (countClear) begin
      rejectCount_next = '0;
    end
    // Event in the clearing cycle still counts
    if (rejectEvent) begin
      if (countClear) begin
        rejectCount_next = CNT_W'(1);
      end else if (rejectCount_reg != {CNT_W{1'b1}}) begin
        rejectCount_next = rejectCount_reg + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rejectCount_reg <= '0;
    end else begin
      rejectCount_reg <= rejectCount_next;
    end
  end

  // ===================================================================
  // Verdict register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      verdict_reg <= '0;
    end else begin
      verdict_reg <= verdict_next;
    end
  end

  assign regRdData  = rdData_reg;
  assign verdict    = verdict_reg;
  assign filterMask = mask_reg;

  // ===================================================================
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  logic              chkExamined;
  logic              chkLocal;
  logic              chkInRange;
  logic              chkExpectBit;
  logic [NODE_W-1:0] chkIndex;

  always_comb begin
    chkExamined = pktReq.valid && (pktReq.dest == DEST_PHYS || pktReq.dest == DEST_ASYNC_RX);
    chkLocal    = (pktReq.srcBus == localBusId) || (pktReq.srcBus == LOCAL_BUS_ALIAS);
    chkInRange  = (pktReq.srcNode >= NODE_BASE) && (pktReq.srcNode <= NODE_TOP);
    chkIndex    = pktReq.srcNode - NODE_BASE;
    chkExpectBit = chkInRange ? mask_reg[chkIndex[4:0]] : 1'b0;
  end

  a_set_write: assert property (
    regWr && regAddr == OFS_FILTER_SET
    |=> (mask_reg & $past(regWrData)) == $past(regWrData)
        && (mask_reg & ~$past(regWrData)) == ($past(mask_reg) & ~$past(regWrData)))
    else $error("set write did not or-in the data");

  a_clear_write: assert property (
    regWr && regAddr == OFS_FILTER_CLEAR
    |=> mask_reg == ($past(mask_reg) & ~$past(regWrData)))
    else $error("clear write did not remove the data bits");

  a_mask_hold: assert property (
    !(regWr && isFilterAddr(regAddr)) |=> $stable(mask_reg))
    else $error("mask changed without a filter write");

  a_mask_read: assert property (
    regRd && isFilterAddr(regAddr) |=> regRdData == $past(mask_reg))
    else $error("filter read did not return the mask");

  a_read_idle: assert property (
    !regRd |=> regRdData == READ_IDLE)
    else $error("read data not zero outside a read");

  a_remote_gate: assert property (
    chkExamined && !chkLocal
    |=> verdict.valid && verdict.governed && verdict.accept == $past(mask_reg[REMOTE_BIT]))
    else $error("remote request verdict does not follow bit 31");

  a_local_node: assert property (
    chkExamined && chkLocal && chkInRange
    |=> verdict.governed && verdict.accept == $past(chkExpectBit))
    else $error("local node verdict does not follow its mask bit");

  a_lowest_node: assert property (
    chkExamined && chkLocal && pktReq.srcNode == NODE_BASE
    |=> verdict.accept == $past(mask_reg[0]))
    else $error("node 32 not governed by bit 0");

  a_ungoverned: assert property (
    chkExamined && chkLocal && !chkInRange |=> verdict.valid && !verdict.governed)
    else $error("node outside upper range was judged");

  a_other_dest: assert property (
    !chkExamined |=> !verdict.valid && !verdict.accept)
    else $error("packet for another context was examined");

  a_reject_count: assert property (
    verdict_next.governed && !verdict_next.accept && !countClear
    && rejectCount_reg != {CNT_W{1'b1}}
    |=> rejectCount_reg == $past(rejectCount_reg) + CNT_W'(1))
    else $error("rejected request not counted");

  // ===================================================================
  // Reference verdict, rebuilt from the rules by bit index
  // Kept apart from the decoder so a slip in its match loop shows up here
  verdict_s chkVerdict;
  verdict_s chkVerdict_reg;

  always_comb begin
    chkVerdict       = '0;
    chkVerdict.valid = chkExamined;
    if (chkExamined && !chkLocal) begin
      chkVerdict.governed = 1'b1;
      chkVerdict.accept   = mask_reg[REMOTE_BIT];
    end else if (chkExamined && chkInRange) begin
      chkVerdict.governed = 1'b1;
      chkVerdict.accept   = chkExpectBit;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      chkVerdict_reg <= '0;
    end else begin
      chkVerdict_reg <= chkVerdict;
    end
  end

  a_verdict_model: assert property (
    verdict == chkVerdict_reg)
    else $error("verdict differs from the reference decision");

  a_accept_governed: assert property (
    verdict.accept |-> verdict.valid && verdict.governed)
    else $error("accept raised on an unjudged request");

  a_zero_bit_reject: assert property (
    chkExamined && chkLocal && chkInRange && !chkExpectBit
    |=> verdict.governed && !verdict.accept)
    else $error("request from a disabled node was accepted");

  a_remote_reject: assert property (
    chkExamined && !chkLocal && !mask_reg[REMOTE_BIT] |=> !verdict.accept)
    else $error("remote request accepted with bit 31 clear");

  a_top_node: assert property (
    chkExamined && chkLocal && pktReq.srcNode == NODE_TOP
    |=> verdict.governed && verdict.accept == $past(mask_reg[NODE_BITS-1]))
    else $error("node 62 not governed by bit 30");

  a_node_above: assert property (
    chkExamined && chkLocal && pktReq.srcNode == {NODE_W{1'b1}}
    |=> !verdict.governed && !verdict.accept)
    else $error("node 63 was judged by this filter");

  a_verdict_pulse: assert property (
    !pktReq.valid |=> !verdict.valid)
    else $error("verdict raised without a request");

  // ===================================================================
  // Register port and counter checks
  a_unmapped_write: assert property (
    regWr && !isFilterAddr(regAddr) |=> mask_reg == $past(mask_reg))
    else $error("write outside the filter addresses changed the mask");

  a_unmapped_read: assert property (
    regRd && !isFilterAddr(regAddr) && regAddr != OFS_REJECT_COUNT
    |=> regRdData == READ_IDLE)
    else $error("unmapped read returned data");

  a_count_read: assert property (
    regRd && regAddr == OFS_REJECT_COUNT
    |=> regRdData == {{(DATA_W-CNT_W){1'b0}}, $past(rejectCount_reg)})
    else $error("count read did not return the count");

  a_count_clear: assert property (
    countClear && !rejectEvent |=> rejectCount_reg == '0)
    else $error("count write did not clear the count");

  a_count_restart: assert property (
    countClear && rejectEvent |=> rejectCount_reg == CNT_W'(1))
    else $error("reject in the clearing cycle was lost");

  a_count_hold: assert property (
    !countClear && !rejectEvent |=> $stable(rejectCount_reg))
    else $error("count moved without a reject or a clear");

  a_count_saturate: assert property (
    !countClear && rejectCount_reg == {CNT_W{1'b1}} |=> rejectCount_reg == {CNT_W{1'b1}})
    else $error("count wrapped past its ceiling");

  c_remote_accept: cover property (
    chkExamined && !chkLocal && mask_reg[REMOTE_BIT] ##1 verdict.accept);

  c_local_reject: cover property (
    chkExamined && chkLocal && chkInRange ##1 verdict.governed && !verdict.accept);

  c_set_then_clear: cover property (
    regWr && regAddr == OFS_FILTER_SET ##1 regWr && regAddr == OFS_FILTER_CLEAR);

  c_read_back: cover property (
    regRd && isFilterAddr(regAddr) && mask_reg != FILTER_RESET);

  c_count_read: cover property (
    regRd && regAddr == OFS_REJECT_COUNT && rejectCount_reg != '0);

endmodule : async_request_node_filter_high

// File: hw/filter_decide.sv
// Purpose: Combinational accept decision for one incoming request
// Assumes: Request and mask come from the same clock domain
// Notes:   Local-bus nodes below 32 and node 63 are left to other filters; remote nodes follow bit 31
`timescale 1ns/1ns
module filter_decide
  import async_filter_pkg::*;
(
  input  wire logic [DATA_W-1:0] mask,
  input  wire pkt_req_s          req,
  input  wire logic [BUS_W-1:0]  localBusId,
  output verdict_s               verdict
);

  logic [NODE_BITS-1:0] nodeHit;
  logic                 examined;
  logic                 isLocal;
  logic                 inRange;

  // ===================================================================
  // Per-node match
  genvar i;
  generate
    for (i = 0; i < NODE_BITS; i++) begin : g_node
      assign nodeHit[i] = (req.srcNode == NODE_BASE + NODE_W'(i)) && mask[i];
    end
  endgenerate

  // ===================================================================
  // Decision
  always_comb begin
    examined = req.valid && (req.dest == DEST_PHYS || req.dest == DEST_ASYNC_RX);
    isLocal  = (req.srcBus == localBusId) || (req.srcBus == LOCAL_BUS_ALIAS);
    inRange  = (req.srcNode >= NODE_BASE) && (req.srcNode <= NODE_TOP);
    verdict  = '0;
    verdict.valid = examined;
    if (examined) begin
      if (!isLocal) begin
        verdict.governed = 1'b1;
        verdict.accept   = mask[REMOTE_BIT];
      end else if (inRange) begin
        verdict.governed = 1'b1;
        verdict.accept   = |nodeHit;
      end
    end
  end

endmodule : filter_decide

// File: shared/async_filter_pkg.sv
// Purpose: Constants and carriers for the upper-node request filter
// Assumes: One 10 MHz clock, registers reached over a plain strobe port
// Notes:   Offsets are byte addresses of aligned 32-bit words
// =====================================================================
package async_filter_pkg;

  // ===================================================================
  // Widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NODE_W = 6;
  localparam int BUS_W  = 10;

  // ===================================================================
  // Register map
  localparam logic [ADDR_W-1:0] OFS_FILTER_SET   = 12'h100;
  localparam logic [ADDR_W-1:0] OFS_FILTER_CLEAR = 12'h104;
  localparam logic [ADDR_W-1:0] OFS_REJECT_COUNT = 12'h1f0;
  localparam logic [DATA_W-1:0] FILTER_RESET     = 32'h0000_0000;
  localparam logic [DATA_W-1:0] READ_IDLE        = 32'h0000_0000;

  // ===================================================================
  // Field layout
  localparam int                REMOTE_BIT = 31;
  localparam int                NODE_BITS  = 31;
  localparam logic [NODE_W-1:0] NODE_BASE  = 6'h20;
  localparam logic [NODE_W-1:0] NODE_TOP   = 6'h3e;
  localparam logic [BUS_W-1:0]  LOCAL_BUS_ALIAS = 10'h3ff;

  // ===================================================================
  // Carriers
  typedef enum logic [2:0] {
    DEST_PHYS     = 3'b001,
    DEST_ASYNC_RX = 3'b010,
    DEST_OTHER    = 3'b100
  } pkt_dest_e;

  typedef struct packed {
    logic              valid;
    pkt_dest_e         dest;
    logic [BUS_W-1:0]  srcBus;
    logic [NODE_W-1:0] srcNode;
  } pkt_req_s;

  typedef struct packed {
    logic valid;
    logic governed;
    logic accept;
  } verdict_s;

endpackage : async_filter_pkg

// File: testbench/remote_node_model.sv
// Purpose: Remote bus node that issues requests toward the filter
// Assumes: Shares mclk with the filter
// Notes:   One request per call; idle fields then change to fresh values
`timescale 1ns/1ns
module remote_node_model
  import async_filter_pkg::*;
(
  input  wire logic mclk,
  output pkt_req_s  pktReq
);
  // ==================================================================
  // Request driver
  initial pktReq = '0;

  task automatic send(input pkt_dest_e d, input logic [BUS_W-1:0] b,
                      input logic [NODE_W-1:0] n);
    @(posedge mclk);
    pktReq <= '{1'b1, d, b, n};
    @(posedge mclk);
    // Stale fields are inverted so a lingering value cannot pass as a request
    pktReq <= '{1'b0, DEST_OTHER, ~b, ~n};
  endtask : send
endmodule : remote_node_model

// File: testbench/test_async_request_node_filter_high.sv
// Purpose: Self-checking bench for the upper-node request filter
// Assumes: Register master and request source share mclk
// Notes:   Expected mask kept here, never read back from the design
`timescale 1ns/1ns
module test_async_request_node_filter_high
  import async_filter_pkg::*;
;
  logic              mclk;
  logic              rstn;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData;
  logic              regWr;
  logic              regRd;
  logic [DATA_W-1:0] regRdData;
  pkt_req_s          pktReq;
  logic [BUS_W-1:0]  localBusId;
  verdict_s          verdict;
  logic [DATA_W-1:0] filterMask;
  logic [DATA_W-1:0] expMask;
  int                failures;
  int                checksDone;

  async_request_node_filter_high uut (.mclk(mclk), .rstn(rstn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .pktReq(pktReq), .localBusId(localBusId), .verdict(verdict), .filterMask(filterMask));
  remote_node_model src (.mclk(mclk), .pktReq(pktReq));

  // ==================================================================
  // Compare and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkV(input verdict_s got, input verdict_s exp);
    checksDone++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: verdict %b expected %b", $time, got, exp);
    end
  endtask : chkV

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    {regWr, regAddr, regWrData} <= {1'b1, a, d};
    @(posedge mclk);
    regWr <= 1'b0;
    if (a == OFS_FILTER_SET) expMask = expMask | d;
    if (a == OFS_FILTER_CLEAR) expMask = expMask & ~d;
    #1 chk(filterMask, expMask);
  endtask : wr

  // Set then clear on consecutive edges, strobe held high across both
  task automatic wr_back(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] c);
    @(posedge mclk);
    {regWr, regAddr, regWrData} <= {1'b1, OFS_FILTER_SET, s};
    @(posedge mclk);
    {regAddr, regWrData} <= {OFS_FILTER_CLEAR, c};
    expMask = expMask | s;
    #1 chk(filterMask, expMask);
    @(posedge mclk);
    regWr <= 1'b0;
    expMask = expMask & ~c;
    #1 chk(filterMask, expMask);
  endtask : wr_back

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge mclk);
    {regRd, regAddr} <= {1'b1, a};
    @(posedge mclk);
    regRd <= 1'b0;
    #1 chk(regRdData, e);
    @(posedge mclk);
    #1 chk(regRdData, READ_IDLE);
  endtask : rd

  task automatic req(input pkt_dest_e d, input logic [BUS_W-1:0] b,
                     input logic [NODE_W-1:0] n, input verdict_s e);
    src.send(d, b, n);
    #1 chkV(verdict, e);
  endtask : req

  // ==================================================================
  // Scenarios
  task automatic t_reset;
    chk(filterMask, FILTER_RESET);
    rd(OFS_FILTER_CLEAR, FILTER_RESET);
    req(DEST_ASYNC_RX, localBusId, 6'h28, '{1'b1, 1'b1, 1'b0});
    $display("reset test done");
  endtask : t_reset

  task automatic t_setclr;
    wr(OFS_FILTER_SET, 32'hf0f0_0001);
    wr(OFS_FILTER_SET, 32'h0000_0100);
    wr(OFS_FILTER_CLEAR, 32'hf000_0000);
    wr_back(32'h0000_0c00, 32'h0000_0100);
    rd(OFS_FILTER_SET, expMask);
    rd(OFS_FILTER_CLEAR, expMask);
    wr(12'h200, 32'hffff_ffff);
    rd(12'h200, READ_IDLE);
    wr(OFS_FILTER_CLEAR, 32'hffff_ffff);
    $display("set clear test done");
  endtask : t_setclr

  task automatic t_nodes;
    logic [DATA_W-1:0] p;
    p = 32'h5555_5555;
    repeat (2) begin
      wr(OFS_FILTER_CLEAR, 32'hffff_ffff);
      wr(OFS_FILTER_SET, p);
      for (int n = 0; n < NODE_BITS; n++) begin
        req(n[0] ? DEST_PHYS : DEST_ASYNC_RX, n[1] ? LOCAL_BUS_ALIAS : localBusId,
            NODE_W'(n + 32), '{1'b1, 1'b1, p[n]});
      end
      // Node 63 and nodes below 32 belong to other filters
      req(DEST_ASYNC_RX, localBusId, 6'h3f, '{1'b1, 1'b0, 1'b0});
      req(DEST_PHYS, localBusId, 6'h1f, '{1'b1, 1'b0, 1'b0});
      p = 32'h2aaa_aaaa;
    end
    $display("node map test done");
  endtask : t_nodes

  task automatic t_remote;
    wr(OFS_FILTER_CLEAR, 32'hffff_ffff);
    wr(OFS_FILTER_SET, 32'h0000_0100);
    req(DEST_ASYNC_RX, 10'h001, 6'h28, '{1'b1, 1'b1, 1'b0});
    req(DEST_PHYS, localBusId, 6'h28, '{1'b1, 1'b1, 1'b1});
    wr(OFS_FILTER_SET, 32'h8000_0000);
    req(DEST_PHYS, 10'h001, 6'h21, '{1'b1, 1'b1, 1'b1});
    req(DEST_ASYNC_RX, 10'h2a5, 6'h05, '{1'b1, 1'b1, 1'b1});
    src.send(DEST_OTHER, localBusId, 6'h28);
    #1 chk({31'h0, verdict.valid}, 32'h0);
    // Move the own bus number so the old one now counts as remote
    @(posedge mclk);
    localBusId <= 10'h2a5;
    req(DEST_ASYNC_RX, 10'h2a5, 6'h21, '{1'b1, 1'b1, 1'b0});
    req(DEST_PHYS, 10'h005, 6'h21, '{1'b1, 1'b1, 1'b1});
    $display("remote test done");
  endtask : t_remote

  task automatic t_count;
    wr(OFS_REJECT_COUNT, 32'h0000_0000);
    rd(OFS_REJECT_COUNT, 32'h0000_0000);
    req(DEST_PHYS, localBusId, 6'h21, '{1'b1, 1'b1, 1'b0});
    req(DEST_ASYNC_RX, localBusId, 6'h22, '{1'b1, 1'b1, 1'b0});
    req(DEST_PHYS, localBusId, 6'h28, '{1'b1, 1'b1, 1'b1});
    req(DEST_OTHER, localBusId, 6'h21, '{1'b0, 1'b0, 1'b0});
    rd(OFS_REJECT_COUNT, 32'h0000_0002);
    $display("reject count test done");
  endtask : t_count

  task automatic t_rerun;
    wr(OFS_FILTER_SET, 32'h0000_0300);
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    expMask = FILTER_RESET;
    #1 chk(filterMask, FILTER_RESET);
    rd(OFS_FILTER_SET, FILTER_RESET);
    rd(OFS_REJECT_COUNT, 32'h0000_0000);
    req(DEST_PHYS, localBusId, 6'h28, '{1'b1, 1'b1, 1'b0});
    $display("mid-run reset test done");
  endtask : t_rerun

  // ==================================================================
  // Run control
  task automatic end_sim;
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    // Roughly 230 cycles expected; the margin covers a stalled verdict
    repeat (5000) @(posedge mclk);
    failures++;
    end_sim();
  end

  initial begin
    {rstn, regWr, regRd, regAddr, regWrData} = '0;
    localBusId = 10'h005;
    expMask = FILTER_RESET;
    failures = 0;
    checksDone = 0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_setclr();
    t_nodes();
    t_remote();
    t_count();
    t_rerun();
    end_sim();
  end
endmodule : test_async_request_node_filter_high
